// File: bench/ptp_dev_model.sv
/*
 * device model for the trim port: pulse timing, word decode, trial regs,
 * fuses, readback shifter. assumes por_n acts as power-on reset.
 */
module ptp_dev_model
  import ptp_pkg::*;
#(
  parameter int THR_CYC = 1000,
  parameter int ZERO_MAX_CYC = 400,
  parameter int ONE_MIN_CYC = 2000,
  parameter int GAP_MIN_CYC = 400
) (
  input wire logic sys_clk,
  input wire logic por_n,
  input wire logic fault_flag,
  input wire logic serial_program_input,
  output logic readback_output,
  output logic [2:0][7:0] trial_q,
  output logic [2:0][7:0] fuse_q,
  output logic lock_fuse_state,
  output logic parity_fuse_state,
  output logic par_err,
  output logic output_forced_low,
  output logic [2:0][7:0] act_trim,
  output logic [7:0] word_cnt_q,
  output logic [7:0] bad_cnt_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pin, pin_d1, b, rd_q, test_q;
  logic [15:0] hi_q, lo_q;
  logic [36:0] sh_q;
  logic [37:0] w;
  logic [5:0] nbit_q;
  logic [7:0] rsh_q, v, m;
  logic [2:0] rcnt_q;
  logic [1:0] fn, pa;
  assign pin = serial_program_input;
  assign b = hi_q >= THR_CYC;
  assign w = {sh_q, b};
  assign fn = w[25:24];
  assign pa = w[23:22];
  assign v = w[19:12];
  assign m = pa == 2'h0 ? 8'h07 : (pa == 2'h1 ? 8'h7f : 8'hff);
  assign par_err = lock_fuse_state & (^fuse_q ^ parity_fuse_state);
  assign act_trim = lock_fuse_state ? fuse_q : trial_q;
  // any fault flag pulls the output to the negative supply
  assign output_forced_low = fault_flag | par_err;
  // released pin shows the inverse, not the last bit
  assign readback_output = rd_q ? rsh_q[7] : ~rsh_q[7];
  always_ff @(posedge sys_clk) begin
    if (!por_n) begin
      pin_d1 <= 1'b0;
      hi_q <= '0;
      lo_q <= '1;
      sh_q <= '0;
      nbit_q <= '0;
      rd_q <= 1'b0;
      rsh_q <= '0;
      rcnt_q <= '0;
      trial_q <= '0;
      fuse_q <= '0;
      lock_fuse_state <= 1'b0;
      parity_fuse_state <= 1'b0;
      test_q <= 1'b0;
      word_cnt_q <= '0;
      bad_cnt_q <= '0;
    end else begin
      pin_d1 <= pin;
      if (pin) hi_q <= hi_q + 16'h0001;
      else if (lo_q != 16'hffff) lo_q <= lo_q + 16'h0001;
      if (pin && !pin_d1) begin
        lo_q <= '0;
        if (lo_q < 16'(GAP_MIN_CYC)) bad_cnt_q <= bad_cnt_q + 8'h01;
      end
      if (!pin && pin_d1) begin
        hi_q <= '0;
        if (hi_q < 16'h0002 || (hi_q > 16'(ZERO_MAX_CYC) &&
            hi_q < 16'(ONE_MIN_CYC)))
          bad_cnt_q <= bad_cnt_q + 8'h01;
        if (rd_q) begin
          rsh_q <= {rsh_q[6:0], 1'b0};
          rcnt_q <= rcnt_q + 3'h1;
          rd_q <= rcnt_q != 3'h7;
        end else if (nbit_q != 6'h25) begin
          sh_q <= w[36:0];
          nbit_q <= nbit_q + 6'h01;
        end else begin
          nbit_q <= '0;
          sh_q <= '0;
          word_cnt_q <= word_cnt_q + 8'h01;
          if (w[37:26] != 12'h801 || w[11:0] != 12'h7fe || w[21:20] != 2'h2)
            bad_cnt_q <= bad_cnt_q + 8'h01;
          else case (fn)
            2'h1: if (!lock_fuse_state && pa != 2'h3)
              trial_q[pa] <= v & m;
            2'h2: if (!lock_fuse_state) begin
              if ($countones(v) != 1) bad_cnt_q <= bad_cnt_q + 8'h01;
              if (pa == 2'h3) begin
                lock_fuse_state <= lock_fuse_state | v[0];
                test_q <= test_q | v[1];
                parity_fuse_state <= parity_fuse_state | v[2];
              end else fuse_q[pa] <= fuse_q[pa] | (v & m);
            end
            2'h3: begin
              rd_q <= 1'b1;
              rcnt_q <= '0;
              rsh_q <= pa == 2'h3 ?
                {5'h00, parity_fuse_state, test_q, lock_fuse_state} : fuse_q[pa];
            end
            default: ;
          endcase
        end
      end
    end
  end
endmodule // ptp_dev_model

// File: bench/ptp_programmer_tb.sv
/*
 * self-checking bench for ptp_programmer driving the device model.
 * assumes ptp_dev_model and a 40 MHz sys_clk.
 */
module ptp_programmer_tb;
  import ptp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_func = 2'h0;
  logic [1:0] cmd_param = 2'h0;
  logic [7:0] cmd_value = 8'h00;
  logic fault_flag = 1'b0;
  logic out_low;
  // pulse timing scaled down tenfold to keep the run short
  localparam int ZERO_CYC = 4;
  localparam int ONE_CYC = 200;
  localparam int GAP_CYC = 40;
  logic cmd_ready_q, cmd_done_q, cmd_error_q, serial_program_input;
  logic readback_output, lock, par, par_err, err;
  logic [7:0] read_data_q, words, bad;
  logic [2:0][7:0] trial, fuse, act;
  int error_cnt = 0;
  int total_checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  ptp_programmer #(.FUSE_WAIT_CYC(20), .ZERO_CYC(ZERO_CYC),
    .ONE_CYC(ONE_CYC), .GAP_CYC(GAP_CYC)) u_dut (.sys_clk, .rst_n, .cmd_valid,
    .cmd_func, .cmd_param, .cmd_value, .cmd_ready_q, .cmd_done_q,
    .cmd_error_q, .read_data_q, .serial_program_input, .readback_output);
  ptp_dev_model #(.THR_CYC(100), .ZERO_MAX_CYC(10 * ZERO_CYC),
    .ONE_MIN_CYC(ONE_CYC), .GAP_MIN_CYC(GAP_CYC)) u_dev (.sys_clk,
    .por_n(rst_n), .fault_flag, .serial_program_input,
    .readback_output, .trial_q(trial), .fuse_q(fuse),
    .lock_fuse_state(lock), .parity_fuse_state(par), .par_err,
    .output_forced_low(out_low),
    .act_trim(act), .word_cnt_q(words), .bad_cnt_q(bad));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic cmd(input logic [1:0] f, p, input logic [7:0] v);
    int n;
    n = 0;
    while (cmd_ready_q !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_func = f;
    cmd_param = p;
    cmd_value = v;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (cmd_done_q !== 1'b1 && cmd_error_q !== 1'b1 && n < 20000) begin
      @(negedge sys_clk);
      n++;
    end
    err = cmd_error_q;
    chk({23'h0, n < 20000}, 24'h1, "command hung");
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_trial;
    cmd(2'h1, 2'h0, 8'h03);
    cmd(2'h1, 2'h1, 8'h8b);
    cmd(2'h1, 2'h2, 8'h40);
    chk(trial, 24'h40_0b03, "trial load");
    chk(act, 24'h40_0b03, "active trim from trial");
    chk(words, 24'h3, "word count");
    chk(out_low, 24'h0, "output forced without fault");
    fault_flag = 1'b1;
    @(negedge sys_clk);
    chk(out_low, 24'h1, "fault did not force output");
    fault_flag = 1'b0;
  endtask
  task automatic t_misc;
    cmd(2'h1, 2'h3, 8'h01);
    cmd(2'h0, 2'h0, 8'h00);
    chk(lock, 24'h0, "misc trial acted");
    chk(trial, 24'h40_0b03, "trial changed");
  endtask
  task automatic t_refuse;
    cmd(2'h2, 2'h2, 8'h03);
    chk(err, 24'h1, "two-bit burn not refused");
    chk(words, 24'h5, "refused burn was sent");
  endtask
  task automatic t_burn_read;
    cmd(2'h2, 2'h2, 8'h40);
    chk(err, 24'h0, "one-hot burn refused");
    chk(fuse, 24'h40_0000, "offset burn");
    chk(act, 24'h40_0b03, "fuse used before lock");
    cmd(2'h3, 2'h2, 8'h00);
    chk(read_data_q, 24'h40, "offset readback");
    cmd(2'h3, 2'h0, 8'h00);
    chk(read_data_q, 24'h0, "intact readback");
  endtask
  task automatic t_lock;
    cmd(2'h2, 2'h3, 8'h01);
    cmd(2'h1, 2'h0, 8'h05);
    chk(lock, 24'h1, "lock fuse");
    chk(trial, 24'h40_0b03, "trial after lock");
    chk(act, 24'h40_0000, "trim source after lock");
    chk(par_err, 24'h1, "parity flag");
    chk(out_low, 24'h1, "parity error did not force output");
    cmd(2'h3, 2'h3, 8'h00);
    chk(read_data_q, 24'h01, "misc readback after lock");
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(negedge sys_clk);
    chk({cmd_ready_q, cmd_done_q, serial_program_input, read_data_q},
      24'h0, "outputs in reset");
    chk({trial, fuse}, 24'h0, "device power-up state");
    chk(lock, 24'h0, "lock after power-up");
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(cmd_ready_q, 24'h1, "ready after reset");
    t_trial;
    t_misc;
    t_refuse;
    t_burn_read;
    t_lock;
    chk(bad, 24'h0, "device saw bad timing or framing");
    wrap_up;
  end
  initial begin
    #2_250_000;
    error_cnt++;
    wrap_up;
  end
endmodule // ptp_programmer_tb

// File: core/ptp_programmer.sv
/*
 * programmer for a single-wire pulse-width trim port: builds the 38-bit
 * word from a user command, sends it, waits out fuse burns, reads back.
 * assumes readback_output comes from the device pin (asynchronous).
 */
`include "ptp_cfg.svh"

module ptp_programmer
  import ptp_pkg::*;
#(
  parameter int FUSE_WAIT_CYC = `PTP_FUSE_CYC,
  parameter int ZERO_CYC = `PTP_ZERO_CYC,
  parameter int ONE_CYC = `PTP_ONE_CYC,
  parameter int GAP_CYC = `PTP_GAP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_func,
  input wire logic [1:0] cmd_param,
  input wire logic [7:0] cmd_value,
  output logic cmd_ready_q,
  output logic cmd_done_q,
  output logic cmd_error_q,
  output logic [7:0] read_data_q,
  output logic serial_program_input,
  input wire logic readback_output
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_SEND, ST_FUSE, ST_RB_SAMPLE, ST_RB_PULSE, ST_RB_WAIT
  } ptp_state_e;

  ptp_state_e state_q;
  logic [`PTP_WORD_BITS-1:0] word_q;
  logic [5:0] bit_cnt_q;
  logic [3:0] rb_cnt_q;
  ptp_cnt_t wait_q;
  ptp_func_e func_q;
  logic rb_meta_q;
  logic rb_sync_q;
  logic tx_ready;
  logic tx_valid;
  logic tx_bit;

  function automatic logic one_hot8(input logic [7:0] v);
    return $onehot(v);
  endfunction

  // ----------------------------------------------------------------
  // readback pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rb_meta_q <= 1'b0;
      rb_sync_q <= 1'b0;
    end else begin
      rb_meta_q <= readback_output;
      rb_sync_q <= rb_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // bit sender
  // ----------------------------------------------------------------
  assign tx_valid = tx_ready && ((state_q == ST_SEND &&
                    bit_cnt_q != 6'(`PTP_WORD_BITS)) ||
                    state_q == ST_RB_PULSE);
  // readback clocking pulses are short ones
  assign tx_bit = (state_q == ST_SEND) ? word_q[`PTP_WORD_BITS-1] : 1'b0;

  ptp_pulse_gen #(
    .ZERO_CYC(ZERO_CYC),
    .ONE_CYC(ONE_CYC),
    .GAP_CYC(GAP_CYC)
  ) u_pulse (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .bit_valid(tx_valid),
    .bit_value(tx_bit),
    .bit_ready(tx_ready),
    .pin_q(serial_program_input)
  );

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      word_q <= '0;
      bit_cnt_q <= 6'h00;
      rb_cnt_q <= 4'h0;
      wait_q <= 16'h0000;
      func_q <= PTP_FN_SENSE;
      cmd_ready_q <= 1'b0;
      cmd_done_q <= 1'b0;
      cmd_error_q <= 1'b0;
      read_data_q <= 8'h00;
    end else begin
      cmd_done_q <= 1'b0;
      cmd_error_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          cmd_ready_q <= 1'b1;
          if (cmd_valid && cmd_ready_q) begin
            cmd_ready_q <= 1'b0;
            if (cmd_func == PTP_FN_BURN && !one_hot8(cmd_value)) begin
              cmd_error_q <= 1'b1;
            end else begin
              state_q <= ST_SEND;
              func_q <= ptp_func_e'(cmd_func);
              bit_cnt_q <= 6'h00;
              word_q <= {`PTP_START_PAT,
                         cmd_func, cmd_param,
                         `PTP_FILLER,
                         cmd_value,
                         `PTP_END_PAT};
            end
          end
        end
        ST_SEND: begin
          if (tx_valid) begin
            word_q <= {word_q[`PTP_WORD_BITS-2:0], 1'b0};
            bit_cnt_q <= bit_cnt_q + 6'h01;
          end else if (tx_ready) begin
            // last bit and its gap are done
            if (func_q == PTP_FN_BURN) begin
              state_q <= ST_FUSE;
              wait_q <= ptp_cnt_t'(FUSE_WAIT_CYC - 1);
            end else if (func_q == PTP_FN_READ) begin
              state_q <= ST_RB_SAMPLE;
              rb_cnt_q <= 4'h0;
            end else begin
              state_q <= ST_IDLE;
              cmd_done_q <= 1'b1;
            end
          end
        end
        ST_FUSE: begin
          if (wait_q == 16'h0000) begin
            state_q <= ST_IDLE;
            cmd_done_q <= 1'b1;
          end else begin
            wait_q <= wait_q - 16'h0001;
          end
        end
        ST_RB_SAMPLE: begin
          read_data_q <= {read_data_q[6:0], rb_sync_q};
          state_q <= ST_RB_PULSE;
        end
        ST_RB_PULSE: begin
          if (tx_valid) begin
            rb_cnt_q <= rb_cnt_q + 4'h1;
            state_q <= ST_RB_WAIT;
          end
        end
        ST_RB_WAIT: begin
          if (tx_ready) begin
            // eighth pulse ends readback on the device
            if (rb_cnt_q == 4'(`PTP_READ_BITS)) begin
              state_q <= ST_IDLE;
              cmd_done_q <= 1'b1;
            end else begin
              state_q <= ST_RB_SAMPLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // word and sequence checks
  // ----------------------------------------------------------------
  a_word_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == ST_SEND && bit_cnt_q == 6'h00 |->
    word_q[`PTP_START_MSB:`PTP_START_LSB] == `PTP_START_PAT)
    else $error("start pattern missing");

  a_word_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == ST_SEND && bit_cnt_q == 6'h00 |->
    word_q[`PTP_END_MSB:0] == `PTP_END_PAT)
    else $error("end pattern missing");

  a_word_filler: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == ST_SEND && bit_cnt_q == 6'h00 |->
    word_q[`PTP_FILL_MSB:`PTP_FILL_LSB] == `PTP_FILLER)
    else $error("filler field wrong");

  a_word_length: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(state_q == ST_SEND) |->
    $past(bit_cnt_q) == 6'(`PTP_WORD_BITS))
    else $error("word not 38 bits");

  a_msb_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == ST_SEND && tx_valid |=> word_q[`PTP_WORD_BITS-1] ==
    $past(word_q[`PTP_WORD_BITS-2]))
    else $error("bit order wrong");

  a_burn_onehot: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == ST_SEND && bit_cnt_q == 6'h00 && func_q == PTP_FN_BURN |->
    $onehot(word_q[`PTP_VAL_MSB:`PTP_VAL_LSB]))
    else $error("burn word not one-hot");

  a_read_pulses: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(state_q) == ST_RB_WAIT && state_q == ST_IDLE |->
    $past(rb_cnt_q) == 4'(`PTP_READ_BITS) && cmd_done_q)
    else $error("readback pulse count wrong");

endmodule // ptp_programmer

// File: core/ptp_pulse_gen.sv
/*
 * pulse-width bit sender: one high pulse per bit, then a low gap.
 * assumes the caller offers bit_valid only while bit_ready is high.
 */
`include "ptp_cfg.svh"

module ptp_pulse_gen
  import ptp_pkg::*;
#(
  parameter int ZERO_CYC = `PTP_ZERO_CYC,
  parameter int ONE_CYC = `PTP_ONE_CYC,
  parameter int GAP_CYC = `PTP_GAP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic bit_valid,
  input wire logic bit_value,
  output logic bit_ready,
  output logic pin_q
);

  typedef enum logic [1:0] {PG_IDLE, PG_HIGH, PG_LOW} ptp_pg_state_e;

  ptp_pg_state_e state_q;
  ptp_cnt_t cnt_q;
  logic bit_q;

  assign bit_ready = (state_q == PG_IDLE);

  // ----------------------------------------------------------------
  // pulse sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= PG_IDLE;
      cnt_q <= 16'h0000;
      pin_q <= 1'b0;
      bit_q <= 1'b0;
    end else begin
      case (state_q)
        PG_IDLE: begin
          if (bit_valid) begin
            state_q <= PG_HIGH;
            pin_q <= 1'b1;
            bit_q <= bit_value;
            // short pulse for 0, long pulse for 1
            cnt_q <= bit_value ? ptp_cnt_t'(ONE_CYC - 1)
                               : ptp_cnt_t'(ZERO_CYC - 1);
          end
        end
        PG_HIGH: begin
          if (cnt_q == 16'h0000) begin
            state_q <= PG_LOW;
            pin_q <= 1'b0;
            cnt_q <= ptp_cnt_t'(GAP_CYC - 1);
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        PG_LOW: begin
          if (cnt_q == 16'h0000) begin
            state_q <= PG_IDLE;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: begin
          state_q <= PG_IDLE;
          pin_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks on the pin waveform
  // ----------------------------------------------------------------
  ptp_cnt_t hi_len_q;
  ptp_cnt_t lo_len_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hi_len_q <= 16'h0000;
      lo_len_q <= 16'hffff;
    end else begin
      hi_len_q <= pin_q ? hi_len_q + 16'h0001 : 16'h0000;
      if (pin_q) begin
        lo_len_q <= 16'h0000;
      end else if (lo_len_q != 16'hffff) begin
        lo_len_q <= lo_len_q + 16'h0001;
      end
    end
  end

  a_zero_width: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(pin_q) && !bit_q |-> hi_len_q == ptp_cnt_t'(ZERO_CYC))
    else $error("zero pulse width wrong");

  a_one_width: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(pin_q) && bit_q |-> hi_len_q == ptp_cnt_t'(ONE_CYC))
    else $error("one pulse width wrong");

  a_gap_width: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(pin_q) |-> lo_len_q >= ptp_cnt_t'(GAP_CYC))
    else $error("gap between pulses too short");

endmodule // ptp_pulse_gen

// File: shared/ptp_cfg.svh
/*
 * timing counts and word layout constants for the trim port programmer.
 * assumes a 40 MHz sys_clk; included by the design files by bare name.
 */
`ifndef PTP_CFG_SVH
`define PTP_CFG_SVH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define PTP_CLK_MHZ 40

// ----------------------------------------------------------------
// pulse timing, times in ns
// ----------------------------------------------------------------
`define PTP_ZERO_PULSE_NS 1000
`define PTP_ONE_PULSE_NS 50000
`define PTP_GAP_NS 10000
`define PTP_FUSE_BURN_NS 1000000
// zero pulse must stay under its maximum: round down
`define PTP_ZERO_CYC ((`PTP_ZERO_PULSE_NS * `PTP_CLK_MHZ) / 1000)
// one pulse and gap are minimum times: round up
`define PTP_ONE_CYC ((`PTP_ONE_PULSE_NS * `PTP_CLK_MHZ + 999) / 1000)
`define PTP_GAP_CYC ((`PTP_GAP_NS * `PTP_CLK_MHZ + 999) / 1000)
`define PTP_FUSE_CYC ((`PTP_FUSE_BURN_NS * `PTP_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------
// 38-bit word, bit 37 goes out first
// ----------------------------------------------------------------
`define PTP_WORD_BITS 38
`define PTP_START_PAT 12'h801
`define PTP_END_PAT 12'h7fe
`define PTP_FILLER 2'h2
`define PTP_START_MSB 37
`define PTP_START_LSB 26
`define PTP_FILL_MSB 21
`define PTP_FILL_LSB 20
`define PTP_VAL_MSB 19
`define PTP_VAL_LSB 12
`define PTP_END_MSB 11
`define PTP_READ_BITS 8

`endif

// File: shared/ptp_pkg.sv
/*
 * types shared by the trim port programmer files.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package ptp_pkg;

  // ----------------------------------------------------------------
  // function field codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PTP_FN_SENSE = 2'h0,
    PTP_FN_TRIAL = 2'h1,
    PTP_FN_BURN = 2'h2,
    PTP_FN_READ = 2'h3
  } ptp_func_e;

  // ----------------------------------------------------------------
  // parameter field codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PTP_PAR_GAIN2 = 2'h0,
    PTP_PAR_GAIN1 = 2'h1,
    PTP_PAR_OFFSET = 2'h2,
    PTP_PAR_MISC = 2'h3
  } ptp_param_e;

  typedef logic [15:0] ptp_cnt_t;

endpackage
